// ==== vatu_consts.vh ====
// Constants for the virtual address translation unit
`ifndef VATU_CONSTS_VH
`define VATU_CONSTS_VH
`define VATU_OFS_PEH       32'hff000000
`define VATU_OFS_PEL       32'hff000004
`define VATU_OFS_TBASE     32'hff000008
`define VATU_OFS_EXCA      32'hff00000c
`define VATU_OFS_CTRL      32'hff000010
`define VATU_OFS_PEA       32'hff000034
`define VATU_AREA7_MASK    32'h1fffffff
`define VATU_AREA7_BASE    32'h1f000000
`define VATU_CTRL_RESET    32'h00000000
`define VATU_CTRL_AT       0
`define VATU_CTRL_TI       2
`define VATU_CTRL_URC_LSB  10
`define VATU_CTRL_URB_LSB  18
`define VATU_CTRL_LRUI_LSB 26
`define VATU_PEL_V         8
`define VATU_PEL_SZ0       4
`define VATU_PEL_SZ1       7
`define VATU_PEL_PR_LSB    5
`define VATU_PEL_SH        1
`define VATU_PEL_PPN_LSB   10
`define VATU_SZ_1K         2'h0
`define VATU_SZ_4K         2'h1
`define VATU_SZ_64K        2'h2
`define VATU_SZ_1M         2'h3
`endif

// ==== vatu_match.v ====
// One translation entry compare and address forming
`timescale 1ns/1ns
module vatu_match (
  input  wire        valid_i,
  input  wire [21:0] vpn_i,
  input  wire [7:0]  space_identifier_i,
  input  wire        shared_i,
  input  wire [1:0]  size_i,
  input  wire [18:0] ppn_i,
  input  wire [31:0] vaddr_i,
  input  wire [7:0]  cur_space_identifier_i,
  output wire        hit_o,
  output wire [28:0] paddr_o
);
  `include "vatu_consts.vh"
  reg [21:0] mask;
  // Compare mask per page size
  always @* begin
    case (size_i)
      `VATU_SZ_1K:  mask = 22'h3fffff;
      `VATU_SZ_4K:  mask = 22'h3ffffc;
      `VATU_SZ_64K: mask = 22'h3fffc0;
      default:      mask = 22'h3ffc00;
    endcase
  end
  // Valid, page and space match
  assign hit_o = valid_i & (((vpn_i ^ vaddr_i[31:10]) & mask) == 22'h000000) &
                 (shared_i | (space_identifier_i == cur_space_identifier_i));
  // Page number joined with in-page offset
  assign paddr_o = {(ppn_i & mask[18:0]) | (vaddr_i[28:10] & ~mask[18:0]), vaddr_i[9:0]};
endmodule // vatu_match

// ==== vatu_top.v ====
// Virtual address translation unit with instruction and unified buffers
//
// Functional notes
// - Translate 32-bit virtual address with 8-bit space id to 29-bit address.
// - Four instruction buffer entries and 64 unified buffer entries.
// - Hardware copies unified entries into the instruction buffer on its miss.
// - Pages are 1 KB, 4 KB, 64 KB or 1 MB.
// - Access rights checked separately for privileged and user mode.
// - Miss or protection violation raises an exception instead of access.
// - Registers at control region and area 7 aliases; 32-bit accesses only.
// - Control register resets to zero; other registers undefined.
// - Enable bit 0 disables translation and exceptions, 1 enables it.
// - Invalidate-all bit clears every valid bit and reads as zero.
// - Counter steps per unified access, not on load, wraps at boundary.
// - Faulting virtual address recorded in exception address register.
`timescale 1ns/1ns
module vatu_top #(
  parameter UENT = 64,
  parameter IENT = 4
) (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        req_i,
  input  wire        ifetch_i,
  input  wire        write_i,
  input  wire        priv_i,
  input  wire [31:0] vaddr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [31:0] reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        load_entry_i,
  output reg         done_o,
  output reg  [28:0] paddr_o,
  output reg         miss_o,
  output reg         prot_o,
  output reg  [31:0] reg_rdata_o
);
  `include "vatu_consts.vh"
  // Entry storage: tag = {sh, size, space_identifier, vpn}, data = {pr, ppn}
  reg [21:0] u_vpn [0:UENT-1];
  reg [7:0]  u_space_identifier [0:UENT-1];
  reg        u_sh [0:UENT-1];
  reg [1:0]  u_sz [0:UENT-1];
  reg [18:0] u_ppn [0:UENT-1];
  reg [1:0]  u_pr [0:UENT-1];
  reg [UENT-1:0] u_v_q;
  reg [21:0] i_vpn [0:IENT-1];
  reg [7:0]  i_space_identifier [0:IENT-1];
  reg        i_sh [0:IENT-1];
  reg [1:0]  i_sz [0:IENT-1];
  reg [18:0] i_ppn [0:IENT-1];
  reg [1:0]  i_pr [0:IENT-1];
  reg [IENT-1:0] i_v_q;
  reg [31:0] peh_q, pel_q, tbase_q, exca_q, pea_q;
  reg        at_q;
  reg [5:0]  urc_q, urb_q, lrui_q;
  wire [UENT-1:0] u_hit;
  wire [28:0]     u_pa [0:UENT-1];
  wire [IENT-1:0] i_hit;
  wire [28:0]     i_pa [0:IENT-1];
  genvar g;
  // Parallel compare of all entries
  generate
    for (g = 0; g < UENT; g = g + 1) begin : g_u
      vatu_match u_m (
        .valid_i    (u_v_q[g]),
        .vpn_i      (u_vpn[g]),
        .space_identifier_i     (u_space_identifier[g]),
        .shared_i   (u_sh[g]),
        .size_i     (u_sz[g]),
        .ppn_i      (u_ppn[g]),
        .vaddr_i    (vaddr_i),
        .cur_space_identifier_i (peh_q[7:0]),
        .hit_o      (u_hit[g]),
        .paddr_o    (u_pa[g])
      );
    end
    for (g = 0; g < IENT; g = g + 1) begin : g_i
      vatu_match i_m (
        .valid_i    (i_v_q[g]),
        .vpn_i      (i_vpn[g]),
        .space_identifier_i     (i_space_identifier[g]),
        .shared_i   (i_sh[g]),
        .size_i     (i_sz[g]),
        .ppn_i      (i_ppn[g]),
        .vaddr_i    (vaddr_i),
        .cur_space_identifier_i (peh_q[7:0]),
        .hit_o      (i_hit[g]),
        .paddr_o    (i_pa[g])
      );
    end
  endgenerate
  // Select first hitting entry of each buffer
  reg [5:0]  u_idx;
  reg [1:0]  i_idx;
  reg        u_any, i_any;
  integer k;
  always @* begin
    u_idx = 6'h00;
    u_any = 1'b0;
    i_idx = 2'h0;
    i_any = 1'b0;
    for (k = UENT - 1; k >= 0; k = k - 1) begin
      if (u_hit[k]) begin
        u_idx = k[5:0];
        u_any = 1'b1;
      end
    end
    for (k = IENT - 1; k >= 0; k = k - 1) begin
      if (i_hit[k]) begin
        i_idx = k[1:0];
        i_any = 1'b1;
      end
    end
  end
  // Victim instruction entry from recency bits
  reg [1:0] i_vic;
  always @* begin
    if (lrui_q[5:3] == 3'h7)
      i_vic = 2'h0;
    else if (!lrui_q[5] && lrui_q[2:1] == 2'h3)
      i_vic = 2'h1;
    else if (!lrui_q[4] && !lrui_q[2] && lrui_q[0])
      i_vic = 2'h2;
    else
      i_vic = 2'h3;
  end
  // Protection check per mode: pr 0/1 privileged only, 2/3 user; odd allows write
  function allowed;
    input [1:0] pr;
    input       p;
    input       w;
    begin
      allowed = (p | pr[1]) & (~w | pr[0]);
    end
  endfunction
  // Register decode with area 7 alias
  wire [31:0] ra = (reg_addr_i[31:29] == 3'h0) ?
                   ((reg_addr_i & `VATU_AREA7_MASK) | 32'he0000000) : reg_addr_i;
  // Control readback: recency [31:26], boundary [23:18], counter [15:10], enable [0]; invalidate reads 0
  wire [31:0] ctrl_rd = {lrui_q, 2'h0, urb_q, 2'h0, urc_q, 9'h000, at_q};
  wire       u_use = req_i & at_q & (~ifetch_i | ~i_any);
  wire [5:0] urc_inc = urc_q + 6'h01;
  wire [1:0] pel_sz = {pel_q[`VATU_PEL_SZ1], pel_q[`VATU_PEL_SZ0]};
  wire [1:0] pel_pr = pel_q[`VATU_PEL_PR_LSB +: 2];
  // Main sequential process
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      at_q        <= 1'b0;
      urc_q       <= 6'h00;
      urb_q       <= 6'h00;
      lrui_q      <= 6'h00;
      u_v_q       <= {UENT{1'b0}};
      i_v_q       <= {IENT{1'b0}};
      done_o      <= 1'b0;
      miss_o      <= 1'b0;
      prot_o      <= 1'b0;
      paddr_o     <= 29'h00000000;
      reg_rdata_o <= 32'h00000000;
    end else begin
      done_o <= 1'b0;
      miss_o <= 1'b0;
      prot_o <= 1'b0;
      // Translation of a core access
      if (req_i) begin
        if (!at_q) begin
          done_o  <= 1'b1;
          paddr_o <= vaddr_i[28:0];
        end else if (ifetch_i && i_any) begin
          if (allowed(i_pr[i_idx], priv_i, 1'b0)) begin
            done_o  <= 1'b1;
            paddr_o <= i_pa[i_idx];
          end else begin
            prot_o <= 1'b1;
            exca_q <= vaddr_i;
            peh_q[31:10] <= vaddr_i[31:10];
          end
          case (i_idx)
            2'h0: lrui_q[5:3] <= 3'h0;
            2'h1: begin lrui_q[5] <= 1'b1; lrui_q[2:1] <= 2'h0; end
            2'h2: begin lrui_q[4] <= 1'b1; lrui_q[2] <= 1'b1; lrui_q[0] <= 1'b0; end
            default: begin lrui_q[3] <= 1'b1; lrui_q[1:0] <= 2'h3; end
          endcase
        end else if (u_any && allowed(u_pr[u_idx], priv_i, write_i)) begin
          done_o  <= 1'b1;
          paddr_o <= u_pa[u_idx];
          if (ifetch_i) begin
            // Refill instruction buffer from unified hit
            i_vpn[i_vic]  <= u_vpn[u_idx];
            i_space_identifier[i_vic] <= u_space_identifier[u_idx];
            i_sh[i_vic]   <= u_sh[u_idx];
            i_sz[i_vic]   <= u_sz[u_idx];
            i_ppn[i_vic]  <= u_ppn[u_idx];
            i_pr[i_vic]   <= u_pr[u_idx];
            i_v_q[i_vic]  <= 1'b1;
          end
        end else begin
          miss_o <= ~u_any;
          prot_o <= u_any;
          exca_q <= vaddr_i;
          peh_q[31:10] <= vaddr_i[31:10];
        end
      end
      // Replacement counter stepping and wrap
      if (u_use && !load_entry_i)
        urc_q <= (urb_q != 6'h00 && urc_inc == urb_q) ? 6'h00 : urc_inc;
      // Entry load at counter position
      if (load_entry_i) begin
        u_vpn[urc_q]  <= peh_q[31:10];
        u_space_identifier[urc_q] <= peh_q[7:0];
        u_sh[urc_q]   <= pel_q[`VATU_PEL_SH];
        u_sz[urc_q]   <= pel_sz;
        u_ppn[urc_q]  <= pel_q[28:10];
        u_pr[urc_q]   <= pel_pr;
        u_v_q[urc_q]  <= pel_q[`VATU_PEL_V];
      end
      // Register writes, full word only
      if (reg_wr_i) begin
        case (ra)
          `VATU_OFS_PEH:   peh_q   <= reg_wdata_i;
          `VATU_OFS_PEL:   pel_q   <= reg_wdata_i;
          `VATU_OFS_TBASE: tbase_q <= reg_wdata_i;
          `VATU_OFS_EXCA:  exca_q  <= reg_wdata_i;
          `VATU_OFS_PEA:   pea_q   <= reg_wdata_i;
          `VATU_OFS_CTRL: begin
            at_q   <= reg_wdata_i[`VATU_CTRL_AT];
            urc_q  <= reg_wdata_i[`VATU_CTRL_URC_LSB +: 6];
            urb_q  <= reg_wdata_i[`VATU_CTRL_URB_LSB +: 6];
            lrui_q <= reg_wdata_i[`VATU_CTRL_LRUI_LSB +: 6];
            if (reg_wdata_i[`VATU_CTRL_TI]) begin
              u_v_q <= {UENT{1'b0}};
              i_v_q <= {IENT{1'b0}};
            end
          end
          default: ;
        endcase
      end
      // Register reads; unmapped reads return zero
      if (reg_rd_i) begin
        case (ra)
          `VATU_OFS_PEH:   reg_rdata_o <= peh_q;
          `VATU_OFS_PEL:   reg_rdata_o <= pel_q;
          `VATU_OFS_TBASE: reg_rdata_o <= tbase_q;
          `VATU_OFS_EXCA:  reg_rdata_o <= exca_q;
          `VATU_OFS_PEA:   reg_rdata_o <= pea_q;
          `VATU_OFS_CTRL:  reg_rdata_o <= ctrl_rd;
          default:         reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // vatu_top

// ==== vatu_core_model.sv ====
// Core-side model issuing one translated access at a time
`timescale 1ns/1ns
module vatu_core_model (
  input  wire        clock_i,
  output reg         req_o,
  output reg         ifetch_o,
  output reg         write_o,
  output reg         priv_o,
  output reg  [31:0] vaddr_o
);
  // Idle at time zero
  initial begin
    {req_o, ifetch_o, write_o, priv_o, vaddr_o} = 36'h0;
  end
  // One-cycle request; released address shows its inverse so stale values never match
  task access(input f, input w, input p, input [31:0] va);
    @(posedge clock_i);
    #1;
    {req_o, ifetch_o, write_o, priv_o, vaddr_o} = {1'b1, f, w, p, va};
    @(posedge clock_i);
    #1;
    {req_o, vaddr_o} = {1'b0, ~va};
  endtask
endmodule // vatu_core_model

// ==== vatu_assertions.sv ====
// Port checker for the translation unit
`timescale 1ns/1ns
module vatu_checker #(parameter UENT = 64, parameter IENT = 4) (
  input wire        clock_i,
  input wire        reset_n_i,
  input wire        req_i,
  input wire        ifetch_i,
  input wire        write_i,
  input wire        priv_i,
  input wire [31:0] vaddr_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        load_entry_i,
  input wire        done_o,
  input wire [28:0] paddr_o,
  input wire        miss_o,
  input wire        prot_o,
  input wire [31:0] reg_rdata_o
);
  reg  at_q;
  wire any_w = done_o | miss_o | prot_o;
  wire ctl_rd = reg_rd_i && reg_addr_i[7:0] == 8'h10;
  // Shadow of the enable bit
  always @(posedge clock_i) begin
    if (!reset_n_i) at_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i[7:0] == 8'h10) at_q <= reg_wdata_i[0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Every request answered next cycle, nothing unasked
  req_answer_a: assert property (req_i |=> any_w) else $error("no answer");
  no_spurious_a: assert property (!req_i |=> !any_w) else $error("unasked answer");
  one_kind_a: assert property ($onehot0({done_o, miss_o, prot_o})) else $error("two answers");
  // Translation off passes the low address through
  bypass_addr_a: assert property (req_i && !at_q |=>
    done_o && {3'h0, paddr_o} == ($past(vaddr_i) & 32'h1fffffff)) else $error("bypass address");
  ti_reads_zero_a: assert property (ctl_rd |=> !reg_rdata_o[2]) else $error("invalidate bit set");
  at_readback_a: assert property (ctl_rd |=> reg_rdata_o[0] == $past(at_q)) else $error("enable readback");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  paddr_hold_a: assert property ($changed(paddr_o) |-> done_o) else $error("address moved");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i[7:0] == 8'h20 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read");
  reset_clear_a: assert property (disable iff (1'b0) !reset_n_i |=>
    !any_w && paddr_o == 29'h0 && reg_rdata_o == 32'h0) else $error("reset state");
  hit_c: cover property (done_o && at_q);
  miss_c: cover property (miss_o);
  prot_c: cover property (prot_o);
endmodule // vatu_checker
bind vatu_top vatu_checker #(.UENT(UENT), .IENT(IENT)) vatu_checker_i (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req_i), .ifetch_i(ifetch_i), .write_i(write_i),
  .priv_i(priv_i), .vaddr_i(vaddr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .load_entry_i(load_entry_i), .done_o(done_o), .paddr_o(paddr_o),
  .miss_o(miss_o), .prot_o(prot_o), .reg_rdata_o(reg_rdata_o));

// ==== testbench.sv ====
// Self-checking bench for the translation unit
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  reg         clock_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, load_entry_i = 0;
  reg  [31:0] reg_addr_i = 0, reg_wdata_i = 0, va;
  wire        req_i, ifetch_i, write_i, priv_i, done_o, miss_o, prot_o;
  wire [31:0] vaddr_i, reg_rdata_o;
  wire [28:0] paddr_o, msk;
  int         fails = 0, n_checks = 0, s;
  reg  [31:0] va_t [3] = '{32'hfffff000, 32'h80001234, 32'h0abcdef0};
  reg  [28:0] pa_t [3] = '{29'h1ffff000, 29'h00001234, 29'h0abcdef0};
  always #5 clock_i = ~clock_i;
  vatu_top #(.UENT(64), .IENT(4)) vatu_top_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req_i), .ifetch_i(ifetch_i), .write_i(write_i),
    .priv_i(priv_i), .vaddr_i(vaddr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .load_entry_i(load_entry_i), .done_o(done_o), .paddr_o(paddr_o),
    .miss_o(miss_o), .prot_o(prot_o), .reg_rdata_o(reg_rdata_o));
  vatu_core_model vatu_core_model_i (.clock_i(clock_i), .req_o(req_i), .ifetch_o(ifetch_i),
    .write_o(write_i), .priv_o(priv_i), .vaddr_o(vaddr_i));
  // Offset mask of the page size in test
  assign msk = (29'h1 << (s == 0 ? 10 : s == 1 ? 12 : s == 2 ? 16 : 20)) - 29'h1;
  // Register word access, result settled on return
  task rw(input w, input [31:0] a, input [31:0] d);
    @(posedge clock_i);
    #1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
    @(posedge clock_i);
    #1;
    {reg_wr_i, reg_rd_i, reg_wdata_i} = {2'b00, ~d};
  endtask
  // Translated access and its answer kind
  task acc(input f, input w, input p, input [31:0] a, input [2:0] k);
    vatu_core_model_i.access(f, w, p, a);
    `CHK("kind", k, {done_o, miss_o, prot_o})
  endtask
  // Entry load through the staging registers
  task ld(input [31:0] hi, input [31:0] lo);
    rw(1, 32'hff000000, hi);
    rw(1, 32'hff000004, lo);
    @(posedge clock_i);
    #1;
    load_entry_i = 1;
    @(posedge clock_i);
    #1;
    load_entry_i = 0;
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    #1;
    reset_n_i = 1;
    rw(0, 32'hff000010, 0);
    `CHK("ctrl", 32'h0, reg_rdata_o)
    rw(0, 32'h1f000010, 0);
    `CHK("alias", 32'h0, reg_rdata_o)
    rw(0, 32'hff000020, 0);
    `CHK("unmapped", 32'h0, reg_rdata_o)
    for (int i = 0; i < 3; i++) begin
      acc(0, 0, 1, va_t[i], 3'b100);
      `CHK("bypass", pa_t[i], paddr_o)
    end
    rw(1, 32'hff000010, 32'h1);
    rw(1, 32'hff000000, 32'h0);
    acc(0, 0, 1, 32'h00400c00, 3'b010);
    rw(0, 32'hff00000c, 0);
    `CHK("fault", 32'h00400c00, reg_rdata_o)
    rw(0, 32'hff000000, 0);
    `CHK("fault vpn", 22'h001003, reg_rdata_o[31:10])
    for (s = 0; s < 4; s++) begin
      va = {s[3:0] + 4'h1, 28'h00fabcd};
      ld({va[31:10], 10'h05}, {3'h0, 19'h5a5a5, 2'b01, s[1], 2'b11, s[0], 4'h0});
      acc(0, 0, 1, va, 3'b100);
      `CHK("paddr", ({19'h5a5a5, 10'h0} & ~msk) | (va[28:0] & msk), paddr_o)
    end
    rw(0, 32'hff000010, 0);
    `CHK("counter", 6'h05, reg_rdata_o[15:10])
    s = 0;
    va = 32'h100fabcd;
    acc(0, 1, 0, va, 3'b100);
    acc(1, 0, 1, va, 3'b100);
    acc(1, 0, 1, va, 3'b100);
    `CHK("fetch", {19'h5a5a5, va[9:0]}, paddr_o)
    rw(0, 32'hff000010, 0);
    `CHK("fetch count", 6'h07, reg_rdata_o[15:10])
    rw(1, 32'hff000000, 32'h09);
    acc(0, 0, 1, va, 3'b010);
    ld(32'h50000009, {3'h0, 19'h00123, 10'h100});
    acc(0, 0, 0, 32'h50000004, 3'b001);
    acc(0, 0, 1, 32'h50000004, 3'b100);
    acc(0, 1, 1, 32'h50000004, 3'b001);
    rw(1, 32'hff000010, 32'h5);
    acc(0, 0, 1, 32'h50000004, 3'b010);
    acc(1, 0, 1, va, 3'b010);
    rw(0, 32'h1f000010, 0);
    `CHK("invalidate", 1'b0, reg_rdata_o[2])
    rw(1, 32'hff000010, 32'h00080401);
    acc(0, 0, 1, 32'h50000004, 3'b010);
    rw(0, 32'hff000010, 0);
    `CHK("wrap", 6'h00, reg_rdata_o[15:10])
    report_and_stop();
  end
endmodule // testbench
